//--- core/standard_timer.sv
// 10-bit standard timer: compare output, timer/counter and pwm modes
// assumes a one-cycle register port and an asynchronous count clock pin
`timescale 1ns/1ns
`default_nettype none

module standard_timer
   import standard_timer_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output var  logic [DATA_W-1:0] rd_data,
   input  wire logic              count_clk_pin,
   output var  logic              timer_out,
   output var  logic              timer_out_oe,
   output var  logic              match_a_req,
   output var  logic              match_p_req
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic              counter_on_r;
   logic              counter_on_prev_r;
   logic [CMPP_W-1:0] compare_p_value_r;
   ctrl1_t            ctrl1_r;
   logic [CNT_W-1:0]  compare_a_value_r;
   logic [CNT_W-1:0]  cnt_r;
   logic              match_a_flag_r;
   logic              match_p_flag_r;
   logic              cmp_level_r;
   logic              tick_lvl;
   logic              tick_prev_r;
   logic              tick;
   logic              on_rise;
   logic              step;
   mode_t             mode;
   logic              pwm_mode;
   logic              cmp_like;
   logic [1:0]        pin_action;
   logic [CNT_W:0]    cnt_inc;
   logic [CNT_W:0]    p_val;
   logic [CNT_W:0]    a_val;
   logic [CNT_W:0]    period_val;
   logic [CNT_W:0]    duty_val;
   logic              hit_a;
   logic              hit_p;
   logic              clear_cnt;
   logic              set_a;
   logic              set_p;
   logic              clr_a;
   logic              clr_p;
   logic              pwm_act;
   logic              pwm_lvl;
   logic              pin_nxt;
   logic              oe_nxt;
   logic [DATA_W-1:0] rd_nxt;

   // register hit decode, shared by all write and clear paths
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs,
                                    input logic              strobe);
      return strobe && (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // count clock input: synchronise then detect rising edge
   tick_sync #(
      .STAGES   (2)
   ) u_tick_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .async_in (count_clk_pin),
      .sync_out (tick_lvl)
   );

   // edge history of the synchronised tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_prev_r <= 1'b0;
      end else if (ce) begin
         tick_prev_r <= tick_lvl;
      end
   end

   assign tick = tick_lvl & ~tick_prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         counter_on_r      <= 1'b0;
         compare_p_value_r <= CMPP_RST;
      end else if (ce && reg_hit(addr, OFS_CTRL0, wr_en)) begin
         counter_on_r      <= wr_data[CTRL0_ON_BIT];
         compare_p_value_r <= wr_data[CTRL0_CMPP_LO +: CMPP_W];
      end
   end

   // mode, pin action, polarity, swap and clear select
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl1_r <= ctrl1_t'(CTRL1_RST);
      end else if (ce && reg_hit(addr, OFS_CTRL1, wr_en)) begin
         ctrl1_r <= ctrl1_t'(wr_data);
      end
   end

   // compare-A value, an 8-bit low part and a 2-bit high part
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         compare_a_value_r <= CMPA_RST;
      end else if (ce) begin
         if (reg_hit(addr, OFS_CMPA_LO, wr_en)) begin
            compare_a_value_r[7:0] <= wr_data;
         end
         if (reg_hit(addr, OFS_CMPA_HI, wr_en)) begin
            compare_a_value_r[CNT_W-1:8] <= wr_data[HI_BITS_W-1:0];
         end
      end
   end

   // counter-on history for edge detection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         counter_on_prev_r <= 1'b0;
      end else if (ce) begin
         counter_on_prev_r <= counter_on_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode and match decode
   assign mode       = mode_t'({ctrl1_r.mode_select_hi,
                                ctrl1_r.mode_select_lo});
   assign pin_action = {ctrl1_r.pin_action_hi, ctrl1_r.pin_action_lo};
   assign pwm_mode   = (mode == MODE_PWM);
   assign cmp_like   = (mode == MODE_COMPARE) || (mode == MODE_TIMER);
   assign on_rise    = counter_on_r & ~counter_on_prev_r;
   assign step       = counter_on_r & tick;
   assign cnt_inc    = {1'b0, cnt_r} + ONE_STEP;
   assign a_val      = {1'b0, compare_a_value_r};

   // compare-P code in steps of 128, code zero means a full count
   assign p_val = (compare_p_value_r == CMPP_ZERO) ? FULL_PERIOD
                : {1'b0, compare_p_value_r, P_STEP_ZERO};

   // match A never fires on a zero compare value
   assign hit_a = (compare_a_value_r != CMPA_ZERO)
                  && (cnt_inc == a_val);
   assign hit_p = (cnt_inc == p_val);

   // period and duty selection for pwm
   always_comb begin
      if (ctrl1_r.period_duty_swap) begin
         period_val = (compare_a_value_r == CMPA_ZERO) ? FULL_PERIOD
                      : a_val;
         duty_val   = p_val;
      end else begin
         period_val = p_val;
         duty_val   = a_val;
      end
   end

   // clear condition per mode
   always_comb begin
      if (pwm_mode) begin
         clear_cnt = (cnt_inc == period_val);
      end else if (cmp_like) begin
         clear_cnt = ctrl1_r.clear_select ? hit_a : hit_p;
      end else begin
         clear_cnt = hit_p;
      end
   end

   // flag set conditions
   assign set_a = step && hit_a && (mode != MODE_CAPTURE);
   assign set_p = step && hit_p
                  && !(cmp_like && ctrl1_r.clear_select);
   assign clr_a = reg_hit(addr, OFS_FLAGS, wr_en) && wr_data[FLAG_A_BIT];
   assign clr_p = reg_hit(addr, OFS_FLAGS, wr_en) && wr_data[FLAG_P_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // 10-bit counter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= CNT_RST;
      end else if (ce) begin
         if (on_rise) begin
            cnt_r <= CNT_RST;
         end else if (step) begin
            cnt_r <= clear_cnt ? CNT_RST : cnt_inc[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky match flags, set wins over clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         match_a_flag_r <= 1'b0;
         match_p_flag_r <= 1'b0;
      end else if (ce) begin
         match_a_flag_r <= set_a | (match_a_flag_r & ~clr_a);
         match_p_flag_r <= set_p | (match_p_flag_r & ~clr_p);
      end
   end

   // one-cycle requests toward interrupt logic
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         match_a_req <= 1'b0;
         match_p_req <= 1'b0;
      end else if (ce) begin
         match_a_req <= set_a;
         match_p_req <= set_p;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare mode pin level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmp_level_r <= 1'b0;
      end else if (ce) begin
         if (on_rise) begin
            cmp_level_r <= ctrl1_r.output_initial_level;
         end else if (set_a && (mode == MODE_COMPARE)) begin
            unique case (pin_action)
               PA_NONE:   cmp_level_r <= cmp_level_r;
               PA_LOW:    cmp_level_r <= 1'b0;
               PA_HIGH:   cmp_level_r <= 1'b1;
               PA_TOGGLE: cmp_level_r <= ~cmp_level_r;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pwm waveform: active from count zero up to the duty value
   assign pwm_act = ({1'b0, cnt_r} < duty_val);

   always_comb begin
      unique case (pin_action)
         PA_INACTIVE: pwm_lvl = ~ctrl1_r.output_initial_level;
         PA_ACTIVE:   pwm_lvl = ctrl1_r.output_initial_level;
         PA_WAVE:     pwm_lvl = pwm_act ? ctrl1_r.output_initial_level
                                        : ~ctrl1_r.output_initial_level;
         PA_PULSE:    pwm_lvl = ~ctrl1_r.output_initial_level;
      endcase
   end

   // final pin with polarity; undriven outside compare and pwm
   always_comb begin
      unique case (mode)
         MODE_COMPARE: begin
            pin_nxt = cmp_level_r ^ ctrl1_r.output_invert;
            oe_nxt  = 1'b1;
         end
         MODE_PWM: begin
            pin_nxt = pwm_lvl ^ ctrl1_r.output_invert;
            oe_nxt  = 1'b1;
         end
         MODE_CAPTURE, MODE_TIMER: begin
            pin_nxt = 1'b0;
            oe_nxt  = 1'b0;
         end
      endcase
   end

   // registered pin drive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_out    <= 1'b0;
         timer_out_oe <= 1'b0;
      end else if (ce) begin
         timer_out    <= pin_nxt;
         timer_out_oe <= oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, unused and unmapped bits read zero
   always_comb begin
      rd_nxt = '0;
      unique case (addr)
         OFS_CTRL0: begin
            rd_nxt[CTRL0_ON_BIT]             = counter_on_r;
            rd_nxt[CTRL0_CMPP_LO +: CMPP_W]  = compare_p_value_r;
         end
         OFS_CTRL1:   rd_nxt = ctrl1_r;
         OFS_CNT_LO:  rd_nxt = cnt_r[7:0];
         OFS_CNT_HI:  rd_nxt[HI_BITS_W-1:0] = cnt_r[CNT_W-1:8];
         OFS_CMPA_LO: rd_nxt = compare_a_value_r[7:0];
         OFS_CMPA_HI: rd_nxt[HI_BITS_W-1:0] = compare_a_value_r[CNT_W-1:8];
         OFS_FLAGS: begin
            rd_nxt[FLAG_A_BIT] = match_a_flag_r;
            rd_nxt[FLAG_P_BIT] = match_p_flag_r;
         end
         default:     rd_nxt = '0;
      endcase
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= rd_en ? rd_nxt : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_on_rise_zero: assert property (
      ce && on_rise |=> cnt_r == CNT_RST)
      else $error("counter not zeroed on counter-on rise");

   chk_off_holds: assert property (
      !counter_on_r && !on_rise |=> $stable(cnt_r))
      else $error("counter moved while off");

   chk_cmpa_zero_flag: assert property (
      ce && compare_a_value_r == CMPA_ZERO && !match_a_flag_r
      |=> !match_a_flag_r)
      else $error("match A raised with zero compare value");

   chk_no_p_flag: assert property (
      ce && cmp_like && ctrl1_r.clear_select && !match_p_flag_r
      && !set_p |=> !match_p_flag_r)
      else $error("match P flag set with clear-select high");

   chk_clear_on_a: assert property (
      ce && step && !on_rise && cmp_like && ctrl1_r.clear_select
      && hit_a |=> cnt_r == CNT_RST)
      else $error("counter not cleared on match A");

   chk_pwm_period: assert property (
      ce && step && !on_rise && pwm_mode && cnt_inc == period_val
      |=> cnt_r == CNT_RST)
      else $error("pwm counter not cleared at period");

   chk_full_duty: assert property (
      ce && pwm_mode && pin_action == PA_WAVE && duty_val >= period_val
      |=> timer_out == $past(ctrl1_r.output_initial_level
                             ^ ctrl1_r.output_invert))
      else $error("pwm not held active at full duty");

   chk_timer_no_pin: assert property (
      ce && mode == MODE_TIMER |=> !timer_out_oe && !timer_out)
      else $error("pin driven in timer/counter mode");

   chk_set_wins: assert property (
      ce && set_a |=> match_a_flag_r && match_a_req)
      else $error("match A event lost");

   chk_flag_sticky: assert property (
      match_p_flag_r && !(ce && clr_p) |=> match_p_flag_r)
      else $error("match P flag dropped without clear");

   chk_init_level: assert property (
      ce && on_rise && mode == MODE_COMPARE ##1 ce
      |=> timer_out == $past(ctrl1_r.output_initial_level
                             ^ ctrl1_r.output_invert, 2))
      else $error("pin not at initial level after counter-on");

   chk_high_zero: assert property (
      ce && rd_en && addr == OFS_CNT_HI |=> rd_data[7:HI_BITS_W] == '0)
      else $error("counter high unused bits not zero");

   cov_cmp_toggle: cover property (
      set_a && mode == MODE_COMPARE && pin_action == PA_TOGGLE);
   cov_pwm_wrap: cover property (
      step && pwm_mode && clear_cnt ##[1:1000] step && pwm_mode && clear_cnt);
   cov_overflow: cover property (
      step && cmp_like && (&cnt_r));
   cov_flag_race: cover property (set_a && clr_a && ce);

endmodule

`default_nettype wire

//--- core/standard_timer_pkg.sv
// shared constants, register map, field layout and types of the timer
// assumes one 8-bit register port with a 3-bit address
`default_nettype none

package standard_timer_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int CNT_W  = 10;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CMPP_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL0   = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL1   = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_CNT_LO  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_CNT_HI  = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_FLAGS   = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL0_ON_BIT  = 3;
   localparam int CTRL0_CMPP_LO = 0;
   localparam int FLAG_A_BIT    = 0;
   localparam int FLAG_P_BIT    = 1;
   localparam int HI_BITS_W     = 2;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [CMPP_W-1:0] CMPP_RST  = 3'h0;
   localparam logic [CNT_W-1:0]  CMPA_RST  = 10'h000;
   localparam logic [CNT_W-1:0]  CNT_RST   = 10'h000;
   localparam logic [DATA_W-1:0] CTRL1_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // counting constants
   localparam logic [CNT_W:0]    FULL_PERIOD = 11'h400;
   localparam logic [CNT_W:0]    ONE_STEP    = 11'h001;
   localparam logic [6:0]        P_STEP_ZERO = 7'h00;
   localparam logic [CNT_W-1:0]  CMPA_ZERO   = 10'h000;
   localparam logic [CMPP_W-1:0] CMPP_ZERO   = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // pin action codes, compare mode and pwm mode readings
   localparam logic [1:0] PA_NONE     = 2'h0;
   localparam logic [1:0] PA_LOW      = 2'h1;
   localparam logic [1:0] PA_HIGH     = 2'h2;
   localparam logic [1:0] PA_TOGGLE   = 2'h3;
   localparam logic [1:0] PA_INACTIVE = 2'h0;
   localparam logic [1:0] PA_ACTIVE   = 2'h1;
   localparam logic [1:0] PA_WAVE     = 2'h2;
   localparam logic [1:0] PA_PULSE    = 2'h3;

   // operating modes in field order
   typedef enum logic [1:0] {
      MODE_COMPARE,
      MODE_CAPTURE,
      MODE_PWM,
      MODE_TIMER
   } mode_t;

   // second control register layout, bit 7 first
   typedef struct packed {
      logic mode_select_hi;
      logic mode_select_lo;
      logic pin_action_hi;
      logic pin_action_lo;
      logic output_initial_level;
      logic output_invert;
      logic period_duty_swap;
      logic clear_select;
   } ctrl1_t;

endpackage

`default_nettype wire

//--- core/tick_sync.sv
// two-stage synchroniser for the external count clock level
// assumes the input is asynchronous to clk; output is a clean level
`timescale 1ns/1ns
`default_nettype none

module tick_sync #(
   parameter int STAGES = 2
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic [STAGES-1:0] chain_r;

   ////////////////////////////////////////////////////////////////////////////
   // shift chain, only the last stage is read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chain_r <= '0;
      end else if (ce) begin
         chain_r <= {chain_r[STAGES-2:0], async_in};
      end
   end

   assign sync_out = chain_r[STAGES-1];

endmodule

`default_nettype wire

//--- tb/pin_load.sv
// load on the timer output pin: level seen and count of rising edges
// assumes the pin has a pull-down, so an undriven pin reads low
`timescale 1ns/1ns
`default_nettype none

module pin_load (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        pin,
   input  wire logic        pin_oe,
   output var  logic        level,
   output var  logic [15:0] rises
);
   logic prev_r;

   // pull-down wins whenever the block releases the pin
   assign level = pin_oe ? pin : 1'b0;

   // edge counter on the wire level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
         rises  <= 16'h0000;
      end else begin
         prev_r <= level;
         if (level && !prev_r)
            rises <= rises + 16'h0001;
      end
   end
endmodule

`default_nettype wire

//--- tb/test_standard_timer.sv
// register-level tests of the timer in compare, timer and pwm modes
// assumes a one-cycle register port and a slow count clock pin
`timescale 1ns/1ns
`default_nettype none

module test_standard_timer;
   import standard_timer_pkg::*;
   localparam int LIMIT_NS = 100000;
   logic              clk;
   logic              sys_rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] rd_data;
   logic              pin;
   logic              timer_out;
   logic              timer_out_oe;
   logic              match_a_req;
   logic              match_p_req;
   logic              level;
   logic [15:0]       rises;
   logic [DATA_W-1:0] got;
   int                mismatches;
   int                check_count;
   int                a_cnt;
   int                p_cnt;
   logic              ce;

   standard_timer standard_timer_inst (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .count_clk_pin(pin), .timer_out(timer_out),
      .timer_out_oe(timer_out_oe), .match_a_req(match_a_req),
      .match_p_req(match_p_req)
   );

   pin_load pin_load_inst (
      .clk(clk), .sys_rst(sys_rst), .pin(timer_out),
      .pin_oe(timer_out_oe), .level(level), .rises(rises)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock and request pulse counter
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         a_cnt <= 0;
         p_cnt <= 0;
      end else begin
         if (match_a_req === 1'b1)
            a_cnt <= a_cnt + 1;
         if (match_p_req === 1'b1)
            p_cnt <= p_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus, count pin and compare tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) addr <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk) wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge clk) addr <= a;
      rd_en <= 1'b1;
      @(posedge clk) rd_en <= 1'b0;
      #1 got = rd_data;
   endtask

   // each step is a pin high of two cycles and a pin low of three cycles
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk) pin <= 1'b1;
         repeat (2) @(posedge clk);
         pin <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (5) @(posedge clk);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #(LIMIT_NS);
      mismatches++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      {mismatches, check_count} = '0;
      {addr, wr_data, wr_en, rd_en, pin} = '0;
      ce      = 1'b1;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, read-only counter, unmapped place
      rd(3'h3); chk(got, 8'h00);
      rd(3'h4); chk(got, 8'h00);
      rd(3'h7); chk(got, 8'h00);
      wr(3'h2, 8'hFF); rd(3'h2); chk(got, 8'h00);
      wr(3'h5, 8'hFF); rd(3'h5); chk(got, 8'h03);
      // compare mode, clear on A, toggle from low
      wr(3'h1, 8'h31); wr(3'h4, 8'h03); wr(3'h5, 8'h00);
      wr(3'h0, 8'h08); step(0); chk({7'h00, level}, 8'h00);
      step(3);
      rd(3'h6); chk(got, 8'h01);
      rd(3'h2); chk(got, 8'h00);
      chk({7'h00, level}, 8'h01);
      chk(rises[7:0], 8'h01);
      chk(a_cnt[7:0], 8'h01);
      wr(3'h6, 8'h01); rd(3'h6); chk(got, 8'h00);
      wr(3'h1, 8'h35); step(0); chk({7'h00, level}, 8'h00);
      // stop holds the count, restart clears it and sets the pin to the inverted initial level
      step(2); wr(3'h0, 8'h00); step(2);
      rd(3'h2); chk(got, 8'h02);
      wr(3'h0, 8'h08); step(0);
      rd(3'h2); chk(got, 8'h00);
      chk({7'h00, level}, 8'h01);
      // timer mode releases the pin
      wr(3'h1, 8'hC0); step(0); chk({7'h00, timer_out_oe}, 8'h00);
      // pwm, swap 0: period 128 steps, duty compare-A of 2
      wr(3'h0, 8'h00); wr(3'h6, 8'h03);
      wr(3'h1, 8'hA8); wr(3'h4, 8'h02);
      wr(3'h0, 8'h09); step(0); chk({7'h00, level}, 8'h01);
      step(2); chk({7'h00, level}, 8'h00);
      step(126);
      rd(3'h6); chk(got, 8'h03);
      chk(p_cnt[7:0], 8'h01);
      rd(3'h2); chk(got, 8'h00);
      chk({7'h00, level}, 8'h01);
      // forced levels while counting goes on
      wr(3'h1, 8'h88); step(0); chk({7'h00, level}, 8'h00);
      step(3); rd(3'h2); chk(got, 8'h03);
      wr(3'h1, 8'h98); step(0); chk({7'h00, level}, 8'h01);
      // pwm, swap 1: period compare-A of 4, duty 1024 holds high
      wr(3'h0, 8'h00); wr(3'h1, 8'hAA); wr(3'h4, 8'h04);
      wr(3'h0, 8'h08); step(6);
      chk({7'h00, level}, 8'h01);
      rd(3'h2); chk(got, 8'h02);
      // clock enable low: a write is ignored
      @(posedge clk) ce <= 1'b0;
      wr(3'h4, 8'h55);
      @(posedge clk) ce <= 1'b1;
      rd(3'h4); chk(got, 8'h04);
      finish_test();
   end
endmodule

`default_nettype wire
